/* pkg/flash_host_pkg.sv */
/*
 Constants and carrier types for the host-side controller of a sector flash.
 Assumes a 25 MHz clock and an asynchronous 512K x 8 part on the far side.
*/
`default_nettype none
package flash_host_pkg;
    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 19;
    localparam int DATA_W = 8;
    localparam int BYTE_W = 8;
    localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hFF;
    localparam logic [DATA_W-1:0] LOCK_FREE = 8'hFE;
    localparam int POLL_POS = 7;
    localparam int TOGGLE_POS = 6;
    localparam logic [ADDR_W-1:0] LOW_LOCK_ADDR = 19'h00002;
    localparam logic [ADDR_W-1:0] HIGH_LOCK_ADDR = 19'h7FFF2;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 25;
    localparam int LOAD_GAP_US = 150;
    localparam int LOAD_GAP_CYC = LOAD_GAP_US * CLK_MHZ;
    localparam int STROBE_NS = 80;
    localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int READ_NS = 250;
    localparam int READ_CYC = (READ_NS * CLK_MHZ + 999) / 1000;
    localparam int SECTOR_MS = 20;
    localparam int SECTOR_CYC = SECTOR_MS * 1000 * CLK_MHZ;
    localparam int POWER_MS = 10;
    localparam int POWER_CYC = POWER_MS * 1000 * CLK_MHZ;
    localparam int CNT_W = 20;
    // ------------------------------------------------------------
    // Command sequences
    // ------------------------------------------------------------
    localparam int SEQ_MAX = 7;
    localparam int SEQ_W = 3;
    localparam logic [SEQ_W-1:0] LEN_PROTECT = 3'h3;
    localparam logic [SEQ_W-1:0] LEN_ERASE = 3'h6;
    localparam logic [SEQ_W-1:0] LEN_LOCK = 3'h7;
    localparam logic [SEQ_W-1:0] LEN_ID = 3'h3;
    localparam logic [SEQ_W-1:0] LEN_EXIT = 3'h3;

    typedef enum logic [2:0] {
        OP_READ = 3'h0,
        OP_PROGRAM = 3'h1,
        OP_CHIP_ERASE = 3'h2,
        OP_LOCK = 3'h3,
        OP_ID_ENTER = 3'h4,
        OP_ID_EXIT = 3'h5
    } op_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } cmd_word_type;

    typedef struct packed {
        logic chip_select_n;
        logic output_drive_n;
        logic write_strobe_n;
        logic [ADDR_W-1:0] addr_lines;
        logic [DATA_W-1:0] byte_out;
        logic byte_oe;
    } pins_type;
endpackage
`default_nettype wire

/* hw/flash_host.sv */
/*
 Host controller that drives a sector flash over its asynchronous pins.
 Assumes the user holds req_op stable while req_valid waits for req_ready,
 and streams sector bytes through a valid/ready pair with byte index.
*/
`timescale 1ns/100ps
`default_nettype none
module flash_host #(
    parameter int POWER_WAIT = flash_host_pkg::POWER_CYC,
    parameter int DONE_WAIT = flash_host_pkg::SECTOR_CYC,
    parameter flash_host_pkg::cmd_word_type [6:0] SEQ_PROTECT = '0,
    parameter flash_host_pkg::cmd_word_type [6:0] SEQ_ERASE = '0,
    parameter flash_host_pkg::cmd_word_type [6:0] SEQ_LOCK = '0,
    parameter flash_host_pkg::cmd_word_type [6:0] SEQ_ID = '0,
    parameter flash_host_pkg::cmd_word_type [6:0] SEQ_EXIT = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic req_valid,
    output logic req_ready,
    input wire flash_host_pkg::op_type req_op,
    input wire logic [18:0] req_addr,
    input wire logic [1:0] req_lock_sel,
    input wire logic load_valid,
    output logic load_ready,
    input wire logic [7:0] load_index,
    input wire logic [7:0] load_data,
    input wire logic load_last,
    output logic [7:0] rd_data,
    output logic done,
    output logic err,
    output logic [1:0] lock_status,
    output flash_host_pkg::pins_type pins,
    input wire logic [7:0] byte_in
);
    // ------------------------------------------------------------
    // Pin input synchroniser
    // ------------------------------------------------------------
    logic [7:0] sync1_ff, sync2_ff;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync1_ff <= 8'h00;
            sync2_ff <= 8'h00;
        end else if (clk_en) begin
            sync1_ff <= byte_in;
            sync2_ff <= sync1_ff;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    typedef enum logic [8:0] {
        S_POWER = 9'h001, S_IDLE = 9'h002, S_CMD = 9'h004,
        S_LOAD_WAIT = 9'h008, S_PULSE = 9'h010, S_GAP = 9'h020,
        S_READ = 9'h040, S_POLL = 9'h080, S_DONE = 9'h100
    } state_type;

    state_type state_ff, nxt_state;
    flash_host_pkg::pins_type pins_ff, nxt_pins;
    flash_host_pkg::op_type op_ff, nxt_op;
    logic [2:0] idx_ff, nxt_idx;
    logic [19:0] cnt_ff, nxt_cnt;
    logic [19:0] wait_ff, nxt_wait;
    logic [7:0] rd_ff, nxt_rd;
    logic [7:0] last_ff, nxt_last;
    logic [1:0] lock_ff, nxt_lock;
    logic done_ff, nxt_done, err_ff, nxt_err;
    logic final_ff, nxt_final, data_ph_ff, nxt_data_ph, prev_ok_ff;
    logic nxt_prev_ok;
    logic [18:0] sec_ff, nxt_sec;

    flash_host_pkg::cmd_word_type cur_cmd;
    logic [2:0] seq_len;
    logic locked_hit, toggle_same, poll_match;

    always_comb begin
        case (op_ff)
            flash_host_pkg::OP_CHIP_ERASE: begin
                cur_cmd = SEQ_ERASE[idx_ff];
                seq_len = flash_host_pkg::LEN_ERASE;
            end
            flash_host_pkg::OP_LOCK: begin
                cur_cmd = SEQ_LOCK[idx_ff];
                seq_len = flash_host_pkg::LEN_LOCK;
            end
            flash_host_pkg::OP_ID_ENTER: begin
                cur_cmd = SEQ_ID[idx_ff];
                seq_len = flash_host_pkg::LEN_ID;
            end
            flash_host_pkg::OP_ID_EXIT: begin
                cur_cmd = SEQ_EXIT[idx_ff];
                seq_len = flash_host_pkg::LEN_EXIT;
            end
            default: begin
                cur_cmd = SEQ_PROTECT[idx_ff];
                seq_len = flash_host_pkg::LEN_PROTECT;
            end
        endcase
    end

    // Lock state is learnt from any OP_READ at the two lock addresses, in id mode or not; host trusts its own copy
    assign locked_hit = (lock_ff[0] && req_addr[18:14] == 5'h00) ||
                        (lock_ff[1] && req_addr[18:14] == 5'h1F);
    assign toggle_same = (sync2_ff[flash_host_pkg::TOGGLE_POS] ==
                          rd_ff[flash_host_pkg::TOGGLE_POS]);
    assign poll_match = (sync2_ff[flash_host_pkg::POLL_POS] ==
                         last_ff[flash_host_pkg::POLL_POS]);

    always_comb begin
        nxt_state = state_ff;
        nxt_pins = pins_ff;
        nxt_op = op_ff;
        nxt_idx = idx_ff;
        nxt_cnt = cnt_ff + 20'h00001;
        nxt_wait = wait_ff;
        nxt_rd = rd_ff;
        nxt_last = last_ff;
        nxt_lock = lock_ff;
        nxt_done = 1'b0;
        nxt_err = err_ff;
        nxt_final = final_ff;
        nxt_data_ph = data_ph_ff;
        nxt_prev_ok = prev_ok_ff;
        nxt_sec = sec_ff;
        case (state_ff)
            S_POWER: begin
                if (cnt_ff >= 20'(POWER_WAIT - 1)) begin
                    nxt_state = S_IDLE;
                end
            end
            S_IDLE: begin
                nxt_cnt = 20'h00000;
                nxt_idx = 3'h0;
                nxt_final = 1'b0;
                nxt_data_ph = 1'b0;
                if (req_valid) begin
                    nxt_op = req_op;
                    nxt_sec = req_addr;
                    nxt_err = 1'b0;
                    if (req_op == flash_host_pkg::OP_READ) begin
                        nxt_pins.addr_lines = req_addr;
                        nxt_pins.chip_select_n = 1'b0;
                        nxt_pins.output_drive_n = 1'b0;
                        nxt_state = S_READ;
                    end else if ((req_op == flash_host_pkg::OP_PROGRAM &&
                                  locked_hit) ||
                                 (req_op == flash_host_pkg::OP_CHIP_ERASE &&
                                  lock_ff != 2'b00)) begin
                        nxt_err = 1'b1;
                        nxt_done = 1'b1;
                    end else begin
                        nxt_state = S_CMD;
                    end
                end
            end
            S_CMD: begin
                nxt_cnt = 20'h00000;
                nxt_pins.addr_lines = cur_cmd.addr;
                nxt_pins.byte_out = cur_cmd.data;
                nxt_last = cur_cmd.data;
                nxt_final = (idx_ff == seq_len - 3'h1) &&
                            (op_ff != flash_host_pkg::OP_PROGRAM);
                nxt_idx = idx_ff + 3'h1;
                nxt_state = S_PULSE;
            end
            S_LOAD_WAIT: begin
                nxt_cnt = wait_ff;
                nxt_wait = wait_ff + 20'h00001;
                if (load_valid) begin
                    nxt_pins.addr_lines = {sec_ff[18:8], load_index};
                    nxt_pins.byte_out = load_data;
                    nxt_last = load_data;
                    nxt_final = load_last;
                    nxt_cnt = 20'h00000;
                    nxt_state = S_PULSE;
                end else if (wait_ff >= 20'(flash_host_pkg::LOAD_GAP_CYC / 2))
                begin
                    nxt_err = 1'b1;
                    nxt_cnt = 20'h00000;
                    nxt_state = S_POLL;
                end
            end
            S_PULSE: begin
                nxt_pins.byte_oe = 1'b1;
                nxt_pins.output_drive_n = 1'b1;
                nxt_pins.chip_select_n = 1'b0;
                nxt_pins.write_strobe_n = 1'b0;
                if (cnt_ff >= 20'(flash_host_pkg::STROBE_CYC)) begin
                    nxt_pins.write_strobe_n = 1'b1;
                    nxt_cnt = 20'h00000;
                    nxt_state = S_GAP;
                end
            end
            S_GAP: begin
                nxt_pins.chip_select_n = 1'b1;
                nxt_pins.byte_oe = 1'b0;
                nxt_cnt = 20'h00000;
                nxt_wait = 20'h00000;
                if (idx_ff < seq_len && !data_ph_ff) begin
                    nxt_state = S_CMD;
                end else if (op_ff == flash_host_pkg::OP_PROGRAM &&
                             !final_ff) begin
                    nxt_data_ph = 1'b1;
                    nxt_state = S_LOAD_WAIT;
                end else if (op_ff == flash_host_pkg::OP_ID_ENTER ||
                             op_ff == flash_host_pkg::OP_ID_EXIT) begin
                    nxt_state = S_DONE;
                end else begin
                    nxt_prev_ok = 1'b0;
                    nxt_pins.addr_lines = (op_ff == flash_host_pkg::OP_PROGRAM)
                        ? nxt_pins.addr_lines : pins_ff.addr_lines;
                    nxt_state = S_POLL;
                end
            end
            S_READ: begin
                if (cnt_ff >= 20'(flash_host_pkg::READ_CYC + 2)) begin
                    nxt_rd = sync2_ff;
                    if (pins_ff.addr_lines == flash_host_pkg::LOW_LOCK_ADDR)
                    begin
                        nxt_lock[0] = (sync2_ff !=
                                       flash_host_pkg::LOCK_FREE);
                    end
                    if (pins_ff.addr_lines == flash_host_pkg::HIGH_LOCK_ADDR)
                    begin
                        nxt_lock[1] = (sync2_ff !=
                                       flash_host_pkg::LOCK_FREE);
                    end
                    nxt_pins.chip_select_n = 1'b1;
                    nxt_pins.output_drive_n = 1'b1;
                    nxt_state = S_DONE;
                end
            end
            S_POLL: begin
                nxt_wait = wait_ff + 20'h00001;
                nxt_pins.chip_select_n = 1'b0;
                nxt_pins.output_drive_n = 1'b0;
                if (cnt_ff >= 20'(flash_host_pkg::READ_CYC + 2)) begin
                    nxt_cnt = 20'h00000;
                    nxt_pins.chip_select_n = 1'b1;
                    nxt_pins.output_drive_n = 1'b1;
                    nxt_rd = sync2_ff;
                    nxt_prev_ok = 1'b1;
                    if ((poll_match || op_ff != flash_host_pkg::OP_PROGRAM) &&
                        prev_ok_ff && toggle_same) begin
                        nxt_state = S_DONE;
                    end else if (wait_ff >= 20'(DONE_WAIT)) begin
                        nxt_err = 1'b1;
                        nxt_state = S_DONE;
                    end
                end
            end
            S_DONE: begin
                nxt_done = 1'b1;
                nxt_state = S_IDLE;
            end
            default: nxt_state = S_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_ff <= S_POWER;
            pins_ff <= '{chip_select_n: 1'b1, output_drive_n: 1'b1,
                         write_strobe_n: 1'b1, addr_lines: 19'h00000,
                         byte_out: 8'h00, byte_oe: 1'b0};
            op_ff <= flash_host_pkg::OP_READ;
            idx_ff <= 3'h0;
            cnt_ff <= 20'h00000;
            wait_ff <= 20'h00000;
            rd_ff <= 8'h00;
            last_ff <= 8'h00;
            lock_ff <= 2'b00;
            done_ff <= 1'b0;
            err_ff <= 1'b0;
            final_ff <= 1'b0;
            data_ph_ff <= 1'b0;
            prev_ok_ff <= 1'b0;
            sec_ff <= 19'h00000;
        end else if (clk_en) begin
            state_ff <= nxt_state;
            pins_ff <= nxt_pins;
            op_ff <= nxt_op;
            idx_ff <= nxt_idx;
            cnt_ff <= nxt_cnt;
            wait_ff <= nxt_wait;
            rd_ff <= nxt_rd;
            last_ff <= nxt_last;
            lock_ff <= nxt_lock;
            done_ff <= nxt_done;
            err_ff <= nxt_err;
            final_ff <= nxt_final;
            data_ph_ff <= nxt_data_ph;
            prev_ok_ff <= nxt_prev_ok;
            sec_ff <= nxt_sec;
        end
    end

    assign req_ready = (state_ff == S_IDLE) && clk_en;
    assign load_ready = (state_ff == S_LOAD_WAIT) && clk_en;
    assign rd_data = rd_ff;
    assign done = done_ff;
    assign err = err_ff;
    assign lock_status = lock_ff;
    assign pins = pins_ff;
endmodule
`default_nettype wire

/* bench/flash_host_sva.sv */
/*
 Checker for flash_host, bound to its ports.
 Assumes one clock and the synchronous low reset; clk_en low only freezes.
*/
`timescale 1ns/100ps
`default_nettype none
module flash_host_sva #(
    parameter int POWER_WAIT = 20
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire flash_host_pkg::op_type req_op,
    input wire logic [18:0] req_addr,
    input wire logic done,
    input wire logic err,
    input wire logic [1:0] lock_status,
    input wire flash_host_pkg::pins_type pins
);
    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    int up_cnt_ff;
    int nxt_up_cnt;
    logic take;
    logic boot_hit;
    assign take = req_valid && req_ready;
    assign boot_hit = (lock_status[0] && req_addr[18:14] == 5'h00)
        || (lock_status[1] && req_addr[18:14] == 5'h1F);
    always_comb begin
        nxt_up_cnt = (up_cnt_ff < POWER_WAIT) ? up_cnt_ff + 1 : up_cnt_ff;
        if (!rst_n) begin
            nxt_up_cnt = 0;
        end
    end
    always_ff @(posedge clk) begin
        up_cnt_ff <= nxt_up_cnt;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_no_read_drive: assert property (
        !pins.output_drive_n |-> !pins.byte_oe && pins.write_strobe_n)
        else $error("byte lines driven while reading");
    a_read_select: assert property (
        $fell(pins.output_drive_n) |-> !pins.chip_select_n [*2])
        else $error("read without chip select");
    a_load_form: assert property (
        !pins.write_strobe_n |->
        !pins.chip_select_n && pins.output_drive_n && pins.byte_oe)
        else $error("malformed load pulse");
    a_strobe_width: assert property (
        $fell(pins.write_strobe_n) |-> !pins.write_strobe_n [*2])
        else $error("strobe pulse too short");
    a_sector_hold: assert property (
        !pins.write_strobe_n && !$past(pins.write_strobe_n)
        |-> $stable(pins.addr_lines) && $stable(pins.byte_out))
        else $error("address or data moved in a pulse");
    a_power_hold: assert property (
        req_ready |-> up_cnt_ff >= POWER_WAIT - 1)
        else $error("request taken before power wait");
    a_lock_refuse: assert property (
        take && req_op == flash_host_pkg::OP_PROGRAM && boot_hit
        |=> done && err && pins.chip_select_n)
        else $error("locked block program not refused");
    a_erase_refuse: assert property (
        take && req_op == flash_host_pkg::OP_CHIP_ERASE && lock_status != 2'h0
        |=> done && err && pins.chip_select_n)
        else $error("chip erase not refused under lock");
endmodule
bind flash_host flash_host_sva #(.POWER_WAIT(POWER_WAIT)) u_sva (
    .clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
    .req_op(req_op), .req_addr(req_addr), .done(done), .err(err),
    .lock_status(lock_status), .pins(pins));
`default_nettype wire

/* bench/flash_dev_model.sv */
/*
 Behavioural sector flash sampled on the bench clock.
 Assumes command data AA/90/F0/80/77 for protect, id, exit, erase, lock.
*/
`timescale 1ns/100ps
`default_nettype none
module flash_dev_model #(
    parameter int GAP = 50,
    parameter int BUSY = 40,
    parameter int PWR_ON = 10
) (
    input wire logic clk,
    input wire logic slow,
    input wire flash_host_pkg::pins_type pins,
    output logic [7:0] byte_in
);
    // ------------------------------------------------------------
    // Device
    // ------------------------------------------------------------
    logic [7:0] mem [int];
    logic [7:0] lat [int];
    logic [7:0] kind = 8'h00, last_d = 8'h00, bus_ff = 8'h00, drv;
    logic tog = 1'h0, id_mode = 1'h0, loading = 1'h0;
    logic [1:0] lock = 2'h0;
    logic [10:0] sect = 11'h000;
    int wcnt = 0, gap = 0, busy = 0, low_n = 0, up_t = 0;
    flash_host_pkg::pins_type prv = '1;
    wire logic rd_on = !pins.chip_select_n && !pins.output_drive_n
        && pins.write_strobe_n;
    always @* begin
        if (busy > 0 || loading) drv = {~last_d[7], tog, last_d[5:0]};
        else if (id_mode && pins.addr_lines == flash_host_pkg::LOW_LOCK_ADDR)
            drv = lock[0] ? 8'hFF : flash_host_pkg::LOCK_FREE;
        else if (id_mode && pins.addr_lines == flash_host_pkg::HIGH_LOCK_ADDR)
            drv = lock[1] ? 8'hFF : flash_host_pkg::LOCK_FREE;
        else drv = mem.exists(pins.addr_lines) ? mem[pins.addr_lines] : 8'hFF;
        // Released lines show the inverse, so a stale value never passes
        byte_in = pins.byte_oe ? pins.byte_out : (rd_on ? drv : ~bus_ff);
    end
    always @(posedge clk) begin
        logic [7:0] d, k;
        logic [18:0] a;
        int blen, n;
        d = bus_ff;
        a = prv.addr_lines;
        k = (wcnt == 0) ? d : kind;
        blen = slow ? 2000 : BUSY;
        n = (k == 8'h80) ? 6 : (k == 8'h77) ? 7 : 3;
        if (k != 8'hAA && k != 8'h90 && k != 8'hF0 && n == 3) n = 1;
        bus_ff <= byte_in;
        prv <= pins;
        if (busy > 0) busy <= busy - 1;
        if (up_t < PWR_ON) up_t <= up_t + 1;
        // Strobe seen low on one sample only counts as noise
        low_n <= (!pins.write_strobe_n && !pins.chip_select_n) ? low_n + 1 : 0;
        if (!prv.chip_select_n && !prv.output_drive_n && prv.write_strobe_n
            && !rd_on && (busy > 0 || loading)) tog <= ~tog;
        if (gap > 0) gap <= gap - 1;
        if (gap == 1) begin
            wcnt <= 0;
            if (loading) begin
                loading <= 1'h0;
                busy <= blen;
                if (!((lock[0] && sect[10:6] == 5'h00)
                    || (lock[1] && sect[10:6] == 5'h1F))) begin
                    for (int i = 0; i < 256; i++)
                        mem[{sect, i[7:0]}] = lat.exists(i) ? lat[i] : 8'hFF;
                end
                lat.delete();
            end
        end
        if (!prv.chip_select_n && !prv.write_strobe_n && prv.output_drive_n
            && (pins.chip_select_n || pins.write_strobe_n)
            && low_n > 1 && up_t >= PWR_ON) begin
            gap <= GAP;
            if (loading) begin
                lat[a[7:0]] = d;
                sect <= a[18:8];
                last_d <= d;
            end else begin
                kind <= k;
                wcnt <= (wcnt + 1 == n) ? 0 : wcnt + 1;
                case (k)
                    8'hAA: loading <= (wcnt == 2);
                    8'h90: id_mode <= id_mode || (wcnt == 2);
                    8'hF0: id_mode <= id_mode && (wcnt != 2);
                    8'h80: if (wcnt == 5) begin
                        busy <= blen;
                        if (lock == 2'h0) mem.delete();
                    end
                    8'h77: lock <= (wcnt == 6) ? 2'h3 : lock;
                    default: busy <= blen;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

/* bench/flash_host_tb_top.sv */
/*
 Self-checking bench for flash_host against a behavioural flash.
 Assumes the checker is bound from its own file.
*/
`timescale 1ns/100ps
`default_nettype none
module flash_host_tb_top;
    // ------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------
    localparam int POWER_WAIT = 20;
    typedef struct {
        flash_host_pkg::op_type op;
        logic [18:0] addr;
        logic chk;
        logic [7:0] rd;
    } row_type;
    logic clk, rst_n, clk_en, req_valid, req_ready, load_valid, load_ready;
    logic load_last, done, err, slow;
    flash_host_pkg::op_type req_op;
    flash_host_pkg::pins_type pins;
    logic [18:0] req_addr;
    logic [1:0] req_lock_sel, lock_status;
    logic [7:0] load_index, load_data, rd_data, byte_in;
    logic [7:0] pi [], pd [];
    int error_cnt = 0;
    int n_checks = 0;
    row_type rows [6] = '{
        '{flash_host_pkg::OP_READ, 19'h12345, 1'h1, 8'hFF},
        '{flash_host_pkg::OP_ID_ENTER, 19'h00000, 1'h0, 8'h00},
        '{flash_host_pkg::OP_READ, flash_host_pkg::LOW_LOCK_ADDR, 1'h1, 8'hFE},
        '{flash_host_pkg::OP_READ, flash_host_pkg::HIGH_LOCK_ADDR, 1'h1, 8'hFE},
        '{flash_host_pkg::OP_ID_EXIT, 19'h00000, 1'h0, 8'h00},
        '{flash_host_pkg::OP_CHIP_ERASE, 19'h00000, 1'h0, 8'h00}};
    flash_host #(.POWER_WAIT(POWER_WAIT), .DONE_WAIT(300),
        .SEQ_PROTECT({7{19'h05555, 8'hAA}}), .SEQ_ERASE({7{19'h05555, 8'h80}}),
        .SEQ_LOCK({7{19'h05555, 8'h77}}), .SEQ_ID({7{19'h05555, 8'h90}}),
        .SEQ_EXIT({7{19'h05555, 8'hF0}})) uut (
        .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .req_valid(req_valid),
        .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr),
        .req_lock_sel(req_lock_sel), .load_valid(load_valid),
        .load_ready(load_ready), .load_index(load_index),
        .load_data(load_data), .load_last(load_last), .rd_data(rd_data),
        .done(done), .err(err), .lock_status(lock_status), .pins(pins),
        .byte_in(byte_in));
    flash_dev_model dev (.clk(clk), .slow(slow), .pins(pins),
        .byte_in(byte_in));
    always #20 clk = ~clk;
    task automatic chk_val(logic [7:0] got, logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_flag(logic got, logic exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("Checks %0d, errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic power_up();
        int k = 0;
        do @(negedge clk); while (req_ready !== 1'h1 && ++k < 1000);
        chk_flag(k >= POWER_WAIT - 1 && k < 1000, 1'h1);
    endtask
    task automatic start_req(flash_host_pkg::op_type op, logic [18:0] a);
        int k = 0;
        @(posedge clk);
        req_op <= op;
        req_addr <= a;
        req_valid <= 1'h1;
        do @(negedge clk); while (req_ready !== 1'h1 && ++k < 3000);
        @(posedge clk);
        req_valid <= 1'h0;
    endtask
    task automatic wait_done();
        int k = 0;
        do @(negedge clk); while (done !== 1'h1 && ++k < 3000);
        chk_flag(done, 1'h1);
    endtask
    task automatic do_op(flash_host_pkg::op_type op, logic [18:0] a);
        start_req(op, a);
        wait_done();
    endtask
    task automatic rd_chk(logic [18:0] a, logic [7:0] e);
        do_op(flash_host_pkg::OP_READ, a);
        chk_val(rd_data, e);
    endtask
    // Loads keep valid high between bytes; one edge per handshake
    task automatic prog(logic [18:0] a);
        int k;
        start_req(flash_host_pkg::OP_PROGRAM, a);
        foreach (pi[i]) begin
            k = 0;
            load_index <= pi[i];
            load_data <= pd[i];
            load_last <= (i == pi.size() - 1);
            load_valid <= 1'h1;
            do @(negedge clk); while (load_ready !== 1'h1 && ++k < 3000);
            @(posedge clk);
        end
        load_valid <= 1'h0;
        wait_done();
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        error_cnt++;
        summarize();
    end
    initial begin
        {clk, rst_n, req_valid, load_valid, load_last, slow} = '0;
        {req_addr, req_lock_sel, load_index, load_data} = '0;
        clk_en = 1'h1;
        req_op = flash_host_pkg::OP_READ;
        repeat (2) @(posedge clk);
        chk_flag(pins.chip_select_n, 1'h1);
        rst_n <= 1'h1;
        power_up();
        foreach (rows[i]) begin
            do_op(rows[i].op, rows[i].addr);
            if (rows[i].chk) chk_val(rd_data, rows[i].rd);
            chk_flag(err, 1'h0);
            chk_val({6'h00, lock_status}, 8'h00);
        end
        pi = '{8'h07, 8'h00, 8'hC8, 8'h03};
        pd = '{8'hA5, 8'h3C, 8'h01, 8'h96};
        prog(19'h12300);
        chk_flag(err, 1'h0);
        rd_chk(19'h12307, 8'hA5);
        rd_chk(19'h12303, 8'h96);
        rd_chk(19'h12301, 8'hFF);
        pi = '{8'h00};
        pd = '{8'h77};
        prog(19'h12300);
        rd_chk(19'h12307, 8'hFF);
        rd_chk(19'h12300, 8'h77);
        slow <= 1'h1;
        prog(19'h13300);
        chk_flag(err, 1'h1);
        slow <= 1'h0;
        repeat (2100) @(posedge clk);
        do_op(flash_host_pkg::OP_LOCK, 19'h00000);
        do_op(flash_host_pkg::OP_ID_ENTER, 19'h00000);
        rd_chk(flash_host_pkg::LOW_LOCK_ADDR, 8'hFF);
        rd_chk(flash_host_pkg::HIGH_LOCK_ADDR, 8'hFF);
        chk_val({6'h00, lock_status}, 8'h03);
        do_op(flash_host_pkg::OP_ID_EXIT, 19'h00000);
        do_op(flash_host_pkg::OP_PROGRAM, 19'h00100);
        chk_flag(err, 1'h1);
        do_op(flash_host_pkg::OP_PROGRAM, 19'h7FF00);
        chk_flag(err, 1'h1);
        do_op(flash_host_pkg::OP_CHIP_ERASE, 19'h00000);
        chk_flag(err, 1'h1);
        pi = '{8'h05};
        pd = '{8'hE1};
        prog(19'h12300);
        rd_chk(19'h12305, 8'hE1);
        start_req(flash_host_pkg::OP_READ, 19'h12305);
        clk_en <= 1'h0;
        repeat (20) @(posedge clk);
        chk_flag(done || pins.chip_select_n, 1'h0);
        clk_en <= 1'h1;
        repeat (3) @(posedge clk);
        rst_n <= 1'h0;
        repeat (2) @(posedge clk);
        chk_flag(pins.output_drive_n, 1'h1);
        chk_flag(done, 1'h0);
        rst_n <= 1'h1;
        power_up();
        rd_chk(19'h12305, 8'hE1);
        summarize();
    end
endmodule
`default_nettype wire
